// ===== rtl/mrbuf_pkg.sv
package mrbuf_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] MRBUF_ADDR_DATA = 8'h00;
  localparam logic [7:0] MRBUF_ADDR_CTRL = 8'h04;
  localparam logic [7:0] MRBUF_ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] MRBUF_ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] MRBUF_ADDR_LEVEL = 8'h10;
  // ----------------------------------------
  // data word fields
  // ----------------------------------------
  localparam int MRBUF_FULL_BIT = 15;
  localparam int MRBUF_EMPTY_BIT = 14;
  localparam int MRBUF_TAG_BIT = 12;
  localparam int MRBUF_RESULT_W = 12;
  localparam int MRBUF_DEPTH = 64;
  // ----------------------------------------
  // control and interrupt fields
  // ----------------------------------------
  localparam int MRBUF_CTRL_ENABLE_BIT = 0;
  localparam logic [31:0] MRBUF_CTRL_RESET = 32'h0000_0000;
  localparam int MRBUF_IRQ_W = 3;
  localparam int MRBUF_IRQ_NOT_EMPTY = 0;
  localparam int MRBUF_IRQ_FULL = 1;
  localparam int MRBUF_IRQ_OVERFLOW = 2;
  localparam logic [1:0] MRBUF_RESP_OKAY = 2'h0;
  localparam logic [1:0] MRBUF_RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // measurement sources
  // ----------------------------------------
  typedef enum logic [1:0] {
    MRBUF_SRC_BATTERY = 2'h0,
    MRBUF_SRC_FIRST_AUX = 2'h1,
    MRBUF_SRC_SECOND_AUX = 2'h2,
    MRBUF_SRC_TEMP = 2'h3
  } mrbuf_src_e;
  typedef enum logic [3:0] {
    MRBUF_ST_IDLE = 4'h1,
    MRBUF_ST_BATTERY = 4'h2,
    MRBUF_ST_AUX = 4'h4,
    MRBUF_ST_LAST = 4'h8
  } mrbuf_state_e;
endpackage : mrbuf_pkg

// ===== rtl/mrbuf_order.sv
`timescale 1ns/1ns
// ----------------------------------------
// scan order tracker: flags results that arrive out of the documented order
// ----------------------------------------
module mrbuf_order
  import mrbuf_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // conversion stream
  input wire logic conv_valid,
  input wire mrbuf_src_e conv_src,
  input wire logic scan_start,
  input wire logic port_scan,
  // check
  output logic order_ok
);
  import mrbuf_pkg::*;

  function automatic logic [1:0] mrbuf_rank(input mrbuf_src_e src, input logic port);
    if (port)
      mrbuf_rank = (src == MRBUF_SRC_BATTERY) ? 2'h0 : (src == MRBUF_SRC_FIRST_AUX) ? 2'h1 : 2'h2;
    else
      mrbuf_rank = (src == MRBUF_SRC_FIRST_AUX) ? 2'h0 : (src == MRBUF_SRC_SECOND_AUX) ? 2'h1
                 : 2'h2;
  endfunction : mrbuf_rank

  logic [2:0] next_rank;

  // the sequencer owns the order; this only reports whether it is monotonic
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      next_rank <= 3'h0;
    else if (scan_start)
      next_rank <= 3'h0;
    else if (conv_valid)
      next_rank <= {1'b0, mrbuf_rank(conv_src, port_scan)} + 3'h1;
  end

  always_comb
  begin
    order_ok = !conv_valid || ({1'b0, mrbuf_rank(conv_src, port_scan)} >= next_rank);
  end
endmodule : mrbuf_order

// ===== rtl/mrbuf_fifo.sv
`timescale 1ns/1ns
// ----------------------------------------
// result storage
// ----------------------------------------
module mrbuf_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 64
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write side
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic rd_en,
  output logic [WIDTH-1:0] rd_data,
  // status
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic do_wr;
  logic do_rd;

  assign do_rd = rd_en && (level != '0);
  assign do_wr = wr_en && (level != (AW+1)'(DEPTH));
  assign rd_data = mem[rd_ptr];

  always_ff @(posedge aclk)
  begin
    if (do_wr)
      mem[wr_ptr] <= wr_data;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr <= wr_ptr + AW'(1);
      if (do_rd)
        rd_ptr <= rd_ptr + AW'(1);
      level <= level + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule : mrbuf_fifo

// ===== rtl/mrbuf_top.sv
`timescale 1ns/1ns
module mrbuf_top
  import mrbuf_pkg::*;
#(
  parameter int DEPTH = MRBUF_DEPTH
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // conversion sequencer
  input wire logic conv_valid,
  input wire logic [MRBUF_RESULT_W-1:0] conv_result,
  input wire mrbuf_src_e conv_src,
  input wire logic scan_start,
  input wire logic port_scan,
  // per-channel path when buffer mode is off
  output logic direct_valid,
  output logic [MRBUF_RESULT_W-1:0] direct_result,
  output mrbuf_src_e direct_src,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt and order error
  output logic irq,
  output logic order_err
);
  import mrbuf_pkg::*;

  localparam int LW = $clog2(DEPTH) + 1;

  function automatic logic mrbuf_is_reg(input logic [7:0] a);
    mrbuf_is_reg = (a == MRBUF_ADDR_DATA) || (a == MRBUF_ADDR_CTRL) ||
                   (a == MRBUF_ADDR_IRQ_STATUS) || (a == MRBUF_ADDR_IRQ_MASK) ||
                   (a == MRBUF_ADDR_LEVEL);
  endfunction : mrbuf_is_reg

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic buffer_mode;
  logic [MRBUF_IRQ_W-1:0] irq_status;
  logic [MRBUF_IRQ_W-1:0] irq_mask;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic wr_fire;
  logic rd_fire;
  logic pop;
  logic push;
  logic order_ok;
  logic [MRBUF_RESULT_W:0] fifo_rd;
  logic [LW-1:0] level;
  logic [MRBUF_IRQ_W-1:0] irq_events;
  logic [MRBUF_IRQ_W-1:0] irq_clear;
  logic [15:0] data_word;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  assign push = conv_valid && buffer_mode;
  assign pop = rd_fire && (s_axi_araddr == MRBUF_ADDR_DATA) && (level != '0);

  mrbuf_fifo #(
    .WIDTH(MRBUF_RESULT_W + 1),
    .DEPTH(DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(push),
    .wr_data({(conv_src == MRBUF_SRC_FIRST_AUX) || (conv_src == MRBUF_SRC_TEMP), conv_result}),
    .rd_en(pop),
    .rd_data(fifo_rd),
    .level(level)
  );

  mrbuf_order u_order (
    .aclk(aclk),
    .aresetn(aresetn),
    .conv_valid(conv_valid),
    .conv_src(conv_src),
    .scan_start(scan_start),
    .port_scan(port_scan),
    .order_ok(order_ok)
  );

  // ----------------------------------------
  // data word
  // ----------------------------------------
  // empty flag reflects state after this read, so the last pop already shows empty
  // full flag shows the state before the pop, so reading a full buffer still says full
  always_comb
  begin
    data_word = 16'h0000;
    data_word[MRBUF_FULL_BIT] = (level == LW'(DEPTH));
    data_word[MRBUF_EMPTY_BIT] = (level <= LW'(1));
    if (level != '0)
    begin
      data_word[MRBUF_TAG_BIT] = fifo_rd[MRBUF_RESULT_W];
      data_word[MRBUF_RESULT_W-1:0] = fifo_rd[MRBUF_RESULT_W-1:0];
    end
  end

  // ----------------------------------------
  // direct path
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      direct_valid <= 1'b0;
      direct_result <= '0;
      direct_src <= MRBUF_SRC_BATTERY;
    end
    else
    begin
      direct_valid <= conv_valid && !buffer_mode;
      if (conv_valid)
      begin
        direct_result <= conv_result;
        direct_src <= conv_src;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite write
  // ----------------------------------------
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= MRBUF_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // data word is read-only: writes to it are refused
        s_axi_bresp <= (mrbuf_is_reg(aw_addr) && aw_addr != MRBUF_ADDR_DATA &&
                        aw_addr != MRBUF_ADDR_LEVEL) ? MRBUF_RESP_OKAY : MRBUF_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      buffer_mode <= MRBUF_CTRL_RESET[MRBUF_CTRL_ENABLE_BIT];
      irq_mask <= '0;
    end
    else if (wr_fire && w_strb[0])
    begin
      if (aw_addr == MRBUF_ADDR_CTRL)
        buffer_mode <= w_data[MRBUF_CTRL_ENABLE_BIT];
      if (aw_addr == MRBUF_ADDR_IRQ_MASK)
        irq_mask <= w_data[MRBUF_IRQ_W-1:0];
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  // events follow what the storage really did, so a dropped result never counts as stored
  always_comb
  begin
    irq_events = '0;
    irq_events[MRBUF_IRQ_NOT_EMPTY] = push && (level != LW'(DEPTH));
    irq_events[MRBUF_IRQ_FULL] = push && !pop && (level == LW'(DEPTH - 1));
    irq_events[MRBUF_IRQ_OVERFLOW] = push && (level == LW'(DEPTH));
  end
  assign irq_clear = (wr_fire && w_strb[0] && aw_addr == MRBUF_ADDR_IRQ_STATUS) ?
                     w_data[MRBUF_IRQ_W-1:0] : '0;

  // set wins over a same-cycle clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status <= '0;
    else
      irq_status <= (irq_status & ~irq_clear) | irq_events;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq <= 1'b0;
      order_err <= 1'b0;
    end
    else
    begin
      irq <= |(irq_status & irq_mask);
      order_err <= push && !order_ok;
    end
  end

  // ----------------------------------------
  // axi4-lite read
  // ----------------------------------------
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rresp = MRBUF_RESP_OKAY;
    case (s_axi_araddr)
      MRBUF_ADDR_DATA: next_rdata[15:0] = data_word;
      MRBUF_ADDR_CTRL: next_rdata[MRBUF_CTRL_ENABLE_BIT] = buffer_mode;
      MRBUF_ADDR_IRQ_STATUS: next_rdata[MRBUF_IRQ_W-1:0] = irq_status;
      MRBUF_ADDR_IRQ_MASK: next_rdata[MRBUF_IRQ_W-1:0] = irq_mask;
      MRBUF_ADDR_LEVEL: next_rdata[LW-1:0] = level;
      default: next_rresp = MRBUF_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= MRBUF_RESP_OKAY;
    end
    else
    begin
      // read data is captured with the handshake, so a pop never alters a word in flight
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rresp;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule : mrbuf_top

// ===== verif/mrbuf_top_chk.sv
`timescale 1ns/1ns
module mrbuf_top_chk
  import mrbuf_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // conversion side
  input wire logic conv_valid,
  input wire logic [MRBUF_RESULT_W-1:0] conv_result,
  input wire mrbuf_src_e conv_src,
  input wire logic direct_valid,
  input wire logic [MRBUF_RESULT_W-1:0] direct_result,
  input wire mrbuf_src_e direct_src,
  // bus side
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awready && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  a_word_layout: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0
    && !s_axi_rdata[13]) else $error("reserved bits set");
  a_flags_apart: assert property (s_axi_rvalid |-> !(s_axi_rdata[15] && s_axi_rdata[14]))
    else $error("full and empty together");
  a_direct_cause: assert property (direct_valid |-> $past(conv_valid)
    && direct_src == $past(conv_src) && direct_result == $past(conv_result))
    else $error("direct result without cause");
  a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_rvalid && !s_axi_bvalid && !irq)
    else $error("outputs busy after reset");
endmodule : mrbuf_top_chk

// ===== verif/mrbuf_seq_model.sv
`timescale 1ns/1ns
module mrbuf_seq_model
  import mrbuf_pkg::*;
(
  // clock
  input wire logic aclk,
  // conversion stream
  output logic conv_valid,
  output logic [MRBUF_RESULT_W-1:0] conv_result,
  output mrbuf_src_e conv_src,
  output logic scan_start,
  output logic port_scan
);
  logic [31:0] exp_q[$];
  initial
  begin
    conv_valid = 1'b0;
    conv_result = 12'h0;
    conv_src = MRBUF_SRC_BATTERY;
    scan_start = 1'b0;
    port_scan = 1'b0;
  end
  // idle result lines flip so a stale value never looks valid
  task automatic put(input mrbuf_src_e s, input logic [11:0] r);
    @(posedge aclk);
    conv_valid <= 1'b1;
    conv_src <= s;
    conv_result <= r;
    exp_q.push_back({19'h0, (s inside {MRBUF_SRC_FIRST_AUX, MRBUF_SRC_TEMP}), r});
    @(posedge aclk);
    conv_valid <= 1'b0;
    conv_result <= ~r;
  endtask : put
  task automatic scan(input logic port, input logic [2:0] sel, input logic [11:0] r);
    @(posedge aclk);
    scan_start <= 1'b1;
    port_scan <= port;
    @(posedge aclk);
    scan_start <= 1'b0;
    if (port)
    begin
      put(MRBUF_SRC_BATTERY, r);
      put(MRBUF_SRC_FIRST_AUX, r + 12'h1);
      put(MRBUF_SRC_SECOND_AUX, r + 12'h2);
    end
    else
    begin
      if (sel[0]) put(MRBUF_SRC_FIRST_AUX, r);
      if (sel[1]) put(MRBUF_SRC_SECOND_AUX, r + 12'h1);
      if (sel[2]) put(MRBUF_SRC_TEMP, r + 12'h2);
    end
  endtask : scan
endmodule : mrbuf_seq_model

// ===== verif/test_measurement_result_buffer.sv
`timescale 1ns/1ns
module test_measurement_result_buffer;
  import mrbuf_pkg::*;
  localparam int DEP = 8;
  logic aclk, aresetn, conv_valid, scan_start, port_scan, direct_valid, irq, order_err;
  logic [11:0] conv_result, direct_result;
  mrbuf_src_e conv_src, direct_src;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, e;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int errors, cmp_count;
  mrbuf_top #(.DEPTH(DEP)) dut (.aclk, .aresetn, .conv_valid, .conv_result, .conv_src,
    .scan_start, .port_scan, .direct_valid, .direct_result, .direct_src,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .order_err);
  mrbuf_seq_model seq (.aclk, .conv_valid, .conv_result, .conv_src, .scan_start, .port_scan);
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;
  // ----
  // bus tasks
  // ----
  task automatic check(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x)
    begin
      $display("ERROR %s expected %h seen %h", n, x, g);
      errors++;
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr
  task automatic rdr(input logic [7:0] a, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rdr
  // ----
  // scenarios
  // ----
  task automatic t_idle;
    rdr(MRBUF_ADDR_DATA, MRBUF_RESP_OKAY);
    check("reset word", 32'h4000, rd);
    rdr(8'h14, MRBUF_RESP_SLVERR);
    wr(MRBUF_ADDR_DATA, 32'h1abc, MRBUF_RESP_SLVERR);
    seq.put(MRBUF_SRC_TEMP, 12'h0ab);
    seq.exp_q.delete();
    rdr(MRBUF_ADDR_LEVEL, MRBUF_RESP_OKAY);
    check("level off", 32'h0, rd);
    $display("idle test done");
  endtask : t_idle
  task automatic t_scan;
    wr(MRBUF_ADDR_CTRL, 32'h1, MRBUF_RESP_OKAY);
    seq.scan(1'b1, 3'h0, 12'h100);
    seq.scan(1'b0, 3'h5, 12'h200);
    seq.scan(1'b0, 3'h7, 12'hffe);
    @(posedge aclk);
    check("order err", 32'h0, {31'h0, order_err});
    seq.put(MRBUF_SRC_BATTERY, 12'h555);
    @(posedge aclk);
    check("order err", 32'h1, {31'h0, order_err});
    void'(seq.exp_q.pop_back());
    rdr(MRBUF_ADDR_LEVEL, MRBUF_RESP_OKAY);
    check("level full", DEP, rd);
    rdr(MRBUF_ADDR_IRQ_STATUS, MRBUF_RESP_OKAY);
    check("status", 32'h7, rd);
    // the first read of a full buffer still shows full
    while (seq.exp_q.size() > 0)
    begin
      e = seq.exp_q.pop_front();
      e[14] = (seq.exp_q.size() == 0);
      e[15] = (seq.exp_q.size() == DEP - 1);
      rdr(MRBUF_ADDR_DATA, MRBUF_RESP_OKAY);
      check("data", e, rd);
    end
    rdr(MRBUF_ADDR_DATA, MRBUF_RESP_OKAY);
    check("empty word", 32'h4000, rd);
    $display("scan test done");
  endtask : t_scan
  task automatic t_irq;
    wr(MRBUF_ADDR_IRQ_STATUS, 32'h7, MRBUF_RESP_OKAY);
    seq.put(MRBUF_SRC_SECOND_AUX, 12'h3c3);
    repeat (3) @(posedge aclk);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(MRBUF_ADDR_IRQ_MASK, 32'h1, MRBUF_RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("irq raised", 32'h1, {31'h0, irq});
    rdr(MRBUF_ADDR_DATA, MRBUF_RESP_OKAY);
    check("data", seq.exp_q.pop_front() | 32'h4000, rd);
    wr(MRBUF_ADDR_IRQ_STATUS, 32'h1, MRBUF_RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("irq cleared", 32'h0, {31'h0, irq});
    $display("irq test done");
  endtask : t_irq
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  initial
  begin
    #200000;
    errors++;
    test_done();
  end
  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_idle();
    t_scan();
    t_irq();
    test_done();
  end
endmodule : test_measurement_result_buffer
bind mrbuf_top mrbuf_top_chk chk (.aclk, .aresetn, .conv_valid, .conv_result, .conv_src,
  .direct_valid, .direct_result, .direct_src, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .irq);
